// File: ascp_pkg.sv
// Constants for the serial configuration and result port of the converter.
// Assumes one system clock; every pin reaches the block through synchronisers.
// Notes on behaviour
// R1 - Transfers happen only while chip select low
// R2 - Bits launched on fall, sampled on rise
// R3 - Configuration in and result out run together
// R4 - Transfer opens on recognised chip select fall
// R5 - Eight-bit word configures the next conversion
// R6 - Previous result shifts out during configuration
// R7 - Conversion starts when exchange ends; host raises select
// R8 - Result appears on the following transfer
// R9 - Configuration taken on first eight rises
// R10 - Later input bits ignored until next cycle
// R11 - First four bits steer the multiplexer
// R12 - Differential mode uses adjacent pairs, either polarity
// R13 - Single-ended mode measures against zero reference
// R14 - Pair index, polarity bit choose channels
// R15 - Fifth bit one unipolar, zero bipolar
// R16 - Sixth bit sets next word bit order
// R17 - Last two bits set current word length
// R18 - Chip select acts after two conversion-clock falls
// R19 - Host holds shift clock low during conversion
// R20 - Output enabled only while select recognised low
// R21 - Mux field order: single, polarity, pair bits
package ascp_pkg;

  // Synchroniser lanes
  localparam int SY_CS   = 3;
  localparam int SY_SCLK = 2;
  localparam int SY_DIN  = 1;
  localparam int SY_ACLK = 0;

  // Configuration word field positions, first received bit at the top
  localparam int CFG_BITS  = 8;
  localparam int F_SGL     = 7;
  localparam int F_ODD     = 6;
  localparam int F_PAIR_HI = 5;
  localparam int F_PAIR_LO = 4;
  localparam int F_SPAN    = 3;
  localparam int F_ORDER   = 2;
  localparam int F_LEN_HI  = 1;
  localparam int F_LEN_LO  = 0;

  // Word sizes and timing counts
  localparam int RES_BITS       = 10;
  localparam int OUT_MAX        = 16;
  localparam int DEGLITCH_FALLS = 2;
  localparam int CONV_ACLK      = 44;
  localparam logic [4:0] LEN_8  = 5'h08;
  localparam logic [4:0] LEN_10 = 5'h0a;
  localparam logic [4:0] LEN_12 = 5'h0c;
  localparam logic [4:0] LEN_16 = 5'h10;

  // Reset values
  localparam logic       ORDER_RST = 1'h1;
  localparam logic [7:0] CFG_RST   = 8'h00;

  // Serial sequencer states
  typedef enum logic [3:0] {
    SER_IDLE  = 4'h1,
    SER_WAIT  = 4'h2,
    SER_SHIFT = 4'h4,
    SER_DONE  = 4'h8
  } ascp_ser_e;

  // Conversion pacing states
  typedef enum logic [2:0] {
    CNV_IDLE  = 3'h1,
    CNV_RUN   = 3'h2,
    CNV_STORE = 3'h4
  } ascp_cnv_e;

  // Output word length from the two length bits
  function automatic logic [4:0] ascp_word_len(input logic [1:0] code);
    case (code)
      2'h0:    ascp_word_len = LEN_8;
      2'h1:    ascp_word_len = LEN_10;
      2'h2:    ascp_word_len = LEN_12;
      default: ascp_word_len = LEN_16;
    endcase
  endfunction : ascp_word_len

  // Result placed so that bit 15 leaves first; LSB-first reverses the code
  function automatic logic [15:0] ascp_out_word(input logic [9:0] code, input logic msb_first);
    logic [9:0] rev;
    rev = 10'h000;
    for (int i = 0; i < RES_BITS; i++)
      rev[i] = code[RES_BITS-1-i];
    ascp_out_word = msb_first ? {code, 6'h00} : {rev, 6'h00};
  endfunction : ascp_out_word

endpackage : ascp_pkg

// File: ascp_port.sv
// Serial port of the converter: chip select deglitch, full-duplex shifting,
// conversion pacing on the conversion clock and a small result buffer.
// Assumes the analog core presents its code on sar_code at conversion end.
`timescale 1ns/1ps
`default_nettype none

module ascp_port #(
  parameter int RES_W       = ascp_pkg::RES_BITS,
  parameter int BUF_DEPTH   = 2,
  parameter int CONV_CYCLES = ascp_pkg::CONV_ACLK
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Serial pins
  input  wire logic             cs_n_pin,
  input  wire logic             sclk_pin,
  input  wire logic             din_pin,
  output logic                  dout,
  output logic                  dout_oe,
  // Conversion clock pin
  input  wire logic             aclk_pin,
  // Analog core
  input  wire logic [RES_W-1:0] sar_code,
  output logic                  conv_start,
  output logic                  conv_busy,
  output logic [2:0]            chan_pos_idx,
  output logic [2:0]            chan_neg_idx,
  output logic                  neg_is_ref,
  output logic                  span_select,
  // Status
  output logic                  cs_active
);

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Two-stage synchronisers for every pin, plus edge history
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic       sclk_d_r;
  logic       aclk_d_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_r     <= 4'h8;  // Select idles high in both stages, so no false fall
      s2_r     <= 4'h8;
      sclk_d_r <= 1'h0;
      aclk_d_r <= 1'h0;
    end
    else
    begin
      s1_r     <= {cs_n_pin, sclk_pin, din_pin, aclk_pin};
      s2_r     <= s1_r;
      sclk_d_r <= s2_r[ascp_pkg::SY_SCLK];
      aclk_d_r <= s2_r[ascp_pkg::SY_ACLK];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic aclk_fall;
  logic din_s;

  // Edge detection works on the second stage only
  assign sclk_rise = s2_r[ascp_pkg::SY_SCLK] & ~sclk_d_r;
  assign sclk_fall = ~s2_r[ascp_pkg::SY_SCLK] & sclk_d_r;
  assign aclk_fall = ~s2_r[ascp_pkg::SY_ACLK] & aclk_d_r;
  assign din_s     = s2_r[ascp_pkg::SY_DIN];

  // Chip select deglitch: a changed level must persist over conversion-clock falls
  logic       cs_low_r;
  logic       cs_low_nxt;
  logic [1:0] dg_cnt_r;
  logic [1:0] dg_cnt_nxt;

  // R18 deglitch on falls
  always_comb
  begin
    cs_low_nxt = cs_low_r;
    dg_cnt_nxt = dg_cnt_r;
    if (~s2_r[ascp_pkg::SY_CS] == cs_low_r)
      dg_cnt_nxt = 2'h0;  // Short pulse forgotten
    else if (aclk_fall)
    begin
      if (dg_cnt_r == 2'(ascp_pkg::DEGLITCH_FALLS - 1))
      begin
        cs_low_nxt = ~s2_r[ascp_pkg::SY_CS];
        dg_cnt_nxt = 2'h0;
      end
      else
        dg_cnt_nxt = dg_cnt_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_low_r <= 1'h0;
      dg_cnt_r <= 2'h0;
    end
    else
    begin
      cs_low_r <= cs_low_nxt;
      dg_cnt_r <= dg_cnt_nxt;
    end
  end

  // R18 recognition timing
  a_cs_deglitch: assert property ($changed(cs_low_r) |-> $past(aclk_fall)
    && $past(dg_cnt_r) == 2'(ascp_pkg::DEGLITCH_FALLS - 1)) // R18
    else $error("chip select recognised without two conversion-clock falls");

  // Result buffer: conversion side fills, serial side drains at transfer start
  logic             buf_in_valid;
  logic             buf_in_ready;
  logic             buf_out_valid;
  logic             buf_out_ready;
  logic [RES_W-1:0] buf_mem_r [BUF_DEPTH];
  logic [RES_W-1:0] buf_mem_nxt [BUF_DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    wr_ptr_nxt;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW-1:0]    rd_ptr_nxt;
  logic [PW:0]      buf_cnt_r;
  logic [PW:0]      buf_cnt_nxt;

  assign buf_in_ready  = (buf_cnt_r != (PW+1)'(BUF_DEPTH));
  assign buf_out_valid = (buf_cnt_r != '0);

  // Pointer wrap handles depths that are not a power of two
  always_comb
  begin
    buf_mem_nxt = buf_mem_r;
    wr_ptr_nxt  = wr_ptr_r;
    rd_ptr_nxt  = rd_ptr_r;
    buf_cnt_nxt = buf_cnt_r;
    if (buf_in_valid && buf_in_ready)
    begin
      buf_mem_nxt[wr_ptr_r] = sar_code;
      wr_ptr_nxt = (wr_ptr_r == PW'(BUF_DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
    end
    if (buf_out_valid && buf_out_ready)
      rd_ptr_nxt = (rd_ptr_r == PW'(BUF_DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
    if ((buf_in_valid && buf_in_ready) && !(buf_out_valid && buf_out_ready))
      buf_cnt_nxt = buf_cnt_r + (PW+1)'(1);
    else if (!(buf_in_valid && buf_in_ready) && (buf_out_valid && buf_out_ready))
      buf_cnt_nxt = buf_cnt_r - (PW+1)'(1);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < BUF_DEPTH; i++)
        buf_mem_r[i] <= '0;
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      buf_cnt_r <= '0;
    end
    else
    begin
      buf_mem_r <= buf_mem_nxt;
      wr_ptr_r  <= wr_ptr_nxt;
      rd_ptr_r  <= rd_ptr_nxt;
      buf_cnt_r <= buf_cnt_nxt;
    end
  end

  // Conversion pacing on conversion-clock falls; a full buffer stalls the store
  ascp_pkg::ascp_cnv_e cnv_r;
  ascp_pkg::ascp_cnv_e cnv_nxt;
  logic [5:0]          cnv_cnt_r;
  logic [5:0]          cnv_cnt_nxt;
  logic                conv_start_r;

  // R8 conversion time
  always_comb
  begin
    cnv_nxt      = cnv_r;
    cnv_cnt_nxt  = cnv_cnt_r;
    buf_in_valid = 1'h0;
    case (cnv_r)
      ascp_pkg::CNV_IDLE:
        if (conv_start_r)
        begin
          cnv_nxt     = ascp_pkg::CNV_RUN;
          cnv_cnt_nxt = 6'h00;
        end
      ascp_pkg::CNV_RUN:
        if (aclk_fall)
        begin
          if (cnv_cnt_r == 6'(CONV_CYCLES - 1))
            cnv_nxt = ascp_pkg::CNV_STORE;
          else
            cnv_cnt_nxt = cnv_cnt_r + 6'h01;
        end
      ascp_pkg::CNV_STORE:
      begin
        buf_in_valid = 1'h1;
        if (buf_in_ready)
          cnv_nxt = ascp_pkg::CNV_IDLE;
      end
      default:
        cnv_nxt = ascp_pkg::CNV_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnv_r     <= ascp_pkg::CNV_IDLE;
      cnv_cnt_r <= 6'h00;
    end
    else
    begin
      cnv_r     <= cnv_nxt;
      cnv_cnt_r <= cnv_cnt_nxt;
    end
  end

  assign conv_busy = (cnv_r != ascp_pkg::CNV_IDLE);

  // R8 conversion length
  a_conv_time: assert property ((cnv_r == ascp_pkg::CNV_RUN && aclk_fall
    && cnv_cnt_r == 6'(CONV_CYCLES - 1)) |=> cnv_r == ascp_pkg::CNV_STORE) // R8
    else $error("conversion did not end after its conversion-clock count");

  // Serial sequencer: deglitched select, duplex shift, word length, mux latch
  ascp_pkg::ascp_ser_e ser_r;
  ascp_pkg::ascp_ser_e ser_nxt;
  logic [4:0]          bit_cnt_r;
  logic [4:0]          bit_cnt_nxt;
  logic [3:0]          cfg_cnt_r;
  logic [3:0]          cfg_cnt_nxt;
  logic [7:0]          cfg_r;
  logic [7:0]          cfg_nxt;
  logic [15:0]         shift_r;
  logic [15:0]         shift_nxt;
  logic                dout_r;
  logic                dout_nxt;
  logic                order_r;
  logic                order_nxt;
  logic                conv_start_nxt;
  logic [2:0]          pos_r;
  logic [2:0]          pos_nxt;
  logic [2:0]          neg_r;
  logic [2:0]          neg_nxt;
  logic                ref_r;
  logic                ref_nxt;
  logic                span_r;
  logic                span_nxt;

  always_comb
  begin
    ser_nxt        = ser_r;
    bit_cnt_nxt    = bit_cnt_r;
    cfg_cnt_nxt    = cfg_cnt_r;
    cfg_nxt        = cfg_r;
    shift_nxt      = shift_r;
    dout_nxt       = dout_r;
    order_nxt      = order_r;
    conv_start_nxt = 1'h0;
    pos_nxt        = pos_r;
    neg_nxt        = neg_r;
    ref_nxt        = ref_r;
    span_nxt       = span_r;
    buf_out_ready  = 1'h0;
    case (ser_r)
      // R4 open on recognised fall
      ascp_pkg::SER_IDLE:
        if (cs_low_r)
        begin
          ser_nxt     = ascp_pkg::SER_WAIT;
          bit_cnt_nxt = 5'h00;
          cfg_cnt_nxt = 4'h0;
        end
      // R19 first bit once no conversion is running or a buffered result is ready
      ascp_pkg::SER_WAIT:
        if (!cs_low_r)
          ser_nxt = ascp_pkg::SER_IDLE;
        else if (cnv_r == ascp_pkg::CNV_IDLE || buf_out_valid)
        begin
          // R6 previous result loaded; R16 order from the earlier word
          buf_out_ready = 1'h1;
          shift_nxt = buf_out_valid ?
            ascp_pkg::ascp_out_word(buf_mem_r[rd_ptr_r], order_r) : 16'h0000;
          dout_nxt  = shift_nxt[ascp_pkg::OUT_MAX-1];
          ser_nxt   = ascp_pkg::SER_SHIFT;
        end
      ascp_pkg::SER_SHIFT:
        // R1 dropping select abandons the transfer
        if (!cs_low_r)
          ser_nxt = ascp_pkg::SER_IDLE;
        else if (sclk_rise)
        begin
          // R5 R9 word taken on first eight rises
          if (cfg_cnt_r != 4'(ascp_pkg::CFG_BITS))
          begin
            cfg_nxt     = {cfg_r[6:0], din_s};
            cfg_cnt_nxt = cfg_cnt_r + 4'h1;
          end
          bit_cnt_nxt = bit_cnt_r + 5'h01;
          // R17 exchange length from the current word
          if (cfg_cnt_nxt == 4'(ascp_pkg::CFG_BITS) && bit_cnt_nxt ==
              ascp_pkg::ascp_word_len({cfg_nxt[ascp_pkg::F_LEN_HI], cfg_nxt[ascp_pkg::F_LEN_LO]}))
          begin
            // R7 start conversion at exchange end
            ser_nxt        = ascp_pkg::SER_DONE;
            conv_start_nxt = 1'h1;
            // R11 mux from the leading bits; R21 field order
            // R14 pair index with polarity bit
            pos_nxt = {cfg_nxt[ascp_pkg::F_PAIR_HI], cfg_nxt[ascp_pkg::F_PAIR_LO],
                       cfg_nxt[ascp_pkg::F_ODD]};
            neg_nxt = {cfg_nxt[ascp_pkg::F_PAIR_HI], cfg_nxt[ascp_pkg::F_PAIR_LO],
                       ~cfg_nxt[ascp_pkg::F_ODD]};
            // R12 R13 differential pair or zero reference
            ref_nxt   = cfg_nxt[ascp_pkg::F_SGL];
            // R15 span bit
            span_nxt  = cfg_nxt[ascp_pkg::F_SPAN];
            // R16 order kept for the next word
            order_nxt = cfg_nxt[ascp_pkg::F_ORDER];
          end
        end
        // R2 R3 launch next result bit on fall
        else if (sclk_fall)
        begin
          dout_nxt  = shift_r[ascp_pkg::OUT_MAX-2];
          shift_nxt = {shift_r[14:0], 1'h0};
        end
      // R10 further input ignored until select rises
      ascp_pkg::SER_DONE:
        if (!cs_low_r)
          ser_nxt = ascp_pkg::SER_IDLE;
      default:
        ser_nxt = ascp_pkg::SER_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ser_r        <= ascp_pkg::SER_IDLE;
      bit_cnt_r    <= 5'h00;
      cfg_cnt_r    <= 4'h0;
      cfg_r        <= ascp_pkg::CFG_RST;
      shift_r      <= 16'h0000;
      dout_r       <= 1'h0;
      order_r      <= ascp_pkg::ORDER_RST;
      conv_start_r <= 1'h0;
      pos_r        <= 3'h0;
      neg_r        <= 3'h1;
      ref_r        <= 1'h0;
      span_r       <= 1'h0;
    end
    else
    begin
      ser_r        <= ser_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      cfg_cnt_r    <= cfg_cnt_nxt;
      cfg_r        <= cfg_nxt;
      shift_r      <= shift_nxt;
      dout_r       <= dout_nxt;
      order_r      <= order_nxt;
      conv_start_r <= conv_start_nxt;
      pos_r        <= pos_nxt;
      neg_r        <= neg_nxt;
      ref_r        <= ref_nxt;
      span_r       <= span_nxt;
    end
  end

  // R20 output driven only while select is recognised low
  assign dout_oe      = cs_low_r;
  assign dout         = dout_r;
  assign cs_active    = cs_low_r;
  assign conv_start   = conv_start_r;
  assign chan_pos_idx = pos_r;
  assign chan_neg_idx = neg_r;
  assign neg_is_ref   = ref_r;
  assign span_select  = span_r;

  // R20 enable follows the pin
  a_dout_enable: assert property ($rose(dout_oe) |-> $past(!s2_r[ascp_pkg::SY_CS])) // R20
    else $error("output enabled while chip select pin high");

  // R9 configuration bits only on rises
  a_cfg_on_rise: assert property ((cfg_cnt_r != $past(cfg_cnt_r) && cfg_cnt_r != 4'h0)
    |-> $past(sclk_rise)) // R9
    else $error("configuration bit taken without a shift-clock rise");

  // R10 word frozen after eight bits
  a_cfg_frozen: assert property ((cfg_cnt_r == 4'(ascp_pkg::CFG_BITS)) |=> $stable(cfg_r)) // R10
    else $error("configuration word changed after eight bits");

  // R2 output moves only on falls
  a_launch_fall: assert property ((ser_r == ascp_pkg::SER_SHIFT && !sclk_fall)
    |=> $stable(dout_r)) // R2
    else $error("output bit changed without a shift-clock fall");

  // R7 start at exact word length
  a_start_at_len: assert property (conv_start_r |-> ser_r == ascp_pkg::SER_DONE
    && bit_cnt_r == ascp_pkg::ascp_word_len(cfg_r[1:0]) ##1 cnv_r == ascp_pkg::CNV_RUN) // R7
    else $error("conversion start not tied to end of exchange");

  // R13 single-ended routing
  a_mux_single: assert property ((conv_start_r && cfg_r[ascp_pkg::F_SGL]) |-> neg_is_ref
    && chan_pos_idx == {cfg_r[ascp_pkg::F_PAIR_HI], cfg_r[ascp_pkg::F_PAIR_LO],
                        cfg_r[ascp_pkg::F_ODD]}) // R13
    else $error("single-ended channel not measured against zero reference");

  // R12 adjacent pair routing
  a_mux_pair: assert property ((conv_busy && !neg_is_ref) |-> chan_pos_idx[2:1] ==
    chan_neg_idx[2:1] && chan_pos_idx[0] != chan_neg_idx[0]) // R12
    else $error("differential inputs not an adjacent pair");

endmodule : ascp_port

`default_nettype wire

// File: ascp_host_model.sv
// Host side model: serial master that frames, clocks and samples the port.
// Assumes sys_clk pacing; the shift clock half period is four system cycles.
`timescale 1ns/1ps
`default_nettype none

module ascp_host_model (
  // Clock
  input  wire logic sys_clk,
  // Serial pins
  output var logic  cs_n_pin,
  output var logic  sclk_pin,
  input  wire logic dout,
  input  wire logic dout_oe,
  output var logic  din_pin
);
  // Idle pins at time zero; shift clock stands low outside frames
  initial
  begin
    cs_n_pin = 1'h1;
    sclk_pin = 1'h0;
    din_pin  = 1'h0;
  end

  // Bounded wait for the output enable to reach a level
  task automatic wait_oe(input logic lvl, output bit ok);
    ok = 0;
    for (int k = 0; k < 200 && !ok; k++)
    begin
      @(posedge sys_clk);
      ok = (dout_oe === lvl);
    end
  endtask : wait_oe

  // One frame of n shift clocks; fewer than the word length aborts it
  task automatic xfer(input logic [7:0] cfg, input int n, output logic [15:0] got,
                      output bit ok);
    bit ok2;
    got = 16'h0000;
    @(posedge sys_clk);
    cs_n_pin <= 1'h0;
    // no clocking before the output wakes
    wait_oe(1'h1, ok);
    for (int i = 0; i < n; i++)
    begin
      // launch at fall, junk past the word
      din_pin <= (i < 8) ? cfg[7-i] : i[0];
      repeat (4) @(posedge sys_clk);
      got[i] = dout;
      sclk_pin <= 1'h1;
      repeat (4) @(posedge sys_clk);
      sclk_pin <= 1'h0;
    end
    // close with clock low; released data line shows the inverse
    repeat (4) @(posedge sys_clk);
    cs_n_pin <= 1'h1;
    din_pin  <= ~din_pin;
    wait_oe(1'h0, ok2);
    ok = ok & ok2;
  endtask : xfer

  // select pulse shorter than one conversion clock
  task automatic glitch();
    @(posedge sys_clk);
    cs_n_pin <= 1'h0;
    repeat (2) @(posedge sys_clk);
    cs_n_pin <= 1'h1;
  endtask : glitch
endmodule : ascp_host_model

`default_nettype wire

// File: ascp_port_tb.sv
// Self-checking bench for the serial port: host model, conversion clock, code.
// Assumes a short conversion count so that a full sweep stays quick.
`timescale 1ns/1ps
`default_nettype none

module ascp_port_tb;
  logic        sys_clk;
  logic        rst;
  logic        aclk_pin;
  logic        cs_n_pin;
  logic        sclk_pin;
  logic        din_pin;
  logic        dout;
  logic        dout_oe;
  logic [9:0]  sar_code;
  logic        conv_start;
  logic        conv_busy;
  logic [2:0]  chan_pos_idx;
  logic [2:0]  chan_neg_idx;
  logic        neg_is_ref;
  logic        span_select;
  logic        cs_active;
  int          mismatches;
  int          compares;
  int          cyc;
  int          starts;
  logic [9:0]  prev_code;
  logic        prev_first_bit_order;
  bit          skip;

  ascp_port #(.RES_W(10), .BUF_DEPTH(2), .CONV_CYCLES(4)) dut (
    .sys_clk(sys_clk), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .din_pin(din_pin), .dout(dout), .dout_oe(dout_oe), .aclk_pin(aclk_pin),
    .sar_code(sar_code), .conv_start(conv_start), .conv_busy(conv_busy),
    .chan_pos_idx(chan_pos_idx), .chan_neg_idx(chan_neg_idx),
    .neg_is_ref(neg_is_ref), .span_select(span_select), .cs_active(cs_active));

  ascp_host_model host (
    .sys_clk(sys_clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .dout(dout), .dout_oe(dout_oe), .din_pin(din_pin));

  // System clock and an unrelated conversion clock
  initial
  begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    aclk_pin = 1'h0;
    #7;
    forever #100 aclk_pin = ~aclk_pin;
  end

  // Cycle counter, start pulse counter and hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (conv_start === 1'b1)
      starts++;
    if (cyc == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic int len_of(input logic [1:0] c);
    len_of = (c == 2'h3) ? 16 : 8 + 2 * c;
  endfunction : len_of

  // Received bit i of a word: code first in chosen order, zeros after
  function automatic logic [15:0] exp_word(input logic [9:0] c, input logic first_bit_order, input int n);
    exp_word = 16'h0000;
    for (int i = 0; i < n && i < 10; i++)
      exp_word[i] = first_bit_order ? c[9-i] : c[i];
  endfunction : exp_word

  // One frame, then wait out the conversion and compare; an aborted frame only checks that no conversion started
  task automatic run(input logic [7:0] cfg, input logic [9:0] code, input int n);
    logic [15:0] got;
    bit          ok;
    int          s0;
    bit          full;
    full = (n == len_of(cfg[1:0]));
    s0 = starts;
    sar_code <= code;
    host.xfer(cfg, n, got, ok);
    check("output window", 16'(ok), 16'h1);
    for (int k = 0; k < 200 && conv_busy !== 1'b0; k++)
      @(posedge sys_clk);
    check("busy done", conv_busy, 1'h0);
    if (!full)
    begin
      check("aborted starts", 16'(starts - s0), 16'h0);
      skip = 1;
    end
    else
    begin
      if (!skip)
        check("result word", got, exp_word(prev_code, prev_first_bit_order, n));
      check("starts", 16'(starts - s0), 16'h1);
      check("pos channel", chan_pos_idx, {cfg[5:4], cfg[6]});
      check("ref side", neg_is_ref, cfg[7]);
      if (!cfg[7])
        check("neg channel", chan_neg_idx, {cfg[5:4], ~cfg[6]});
      check("span", span_select, cfg[3]);
      prev_code = code;
      prev_first_bit_order = cfg[2];
      skip = 0;
    end
  endtask : run

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Main sequence
  initial
  begin
    rst = 1'h1;
    sar_code = 10'h000;
    prev_code = 10'h000;
    prev_first_bit_order = 1'h1;
    skip = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    check("oe at reset", dout_oe, 1'h0);
    check("neg at reset", chan_neg_idx, 3'h1);
    check("busy at reset", conv_busy, 1'h0);
    host.glitch();
    repeat (20) @(posedge sys_clk);
    check("glitch select", cs_active, 1'h0);
    check("glitch oe", dout_oe, 1'h0);
    $display("test reset and glitch done");
    // Every mux code, both spans, both orders, all four lengths
    for (int k = 0; k < 16; k++)
      run({k[3:0], k[0], k[1], k[3:2] ^ k[1:0]}, 10'h2c7 + 10'(k * 59),
          len_of(k[3:2] ^ k[1:0]));
    $display("test mux sweep done");
    // One frame with the word complete but select raised before the length is reached, then three full frames
    run(8'h9b, 10'h3a1, 10);
    run(8'h24, 10'h1f0, 8);
    run(8'h53, 10'h0ff, 16);
    run(8'hc2, 10'h24b, 12);
    $display("test abort done");
    stop_test();
  end
endmodule : ascp_port_tb

`default_nettype wire
